/* rax_pkg.sv */
package rax_pkg;

  // register map, byte addresses on the serial control link
  localparam logic [7:0] RAX_ADDR_BUCK3  = 8'h42;
  localparam logic [7:0] RAX_ADDR_BACKUP = 8'h48;
  localparam logic [7:0] RAX_ADDR_MEMREF = 8'h4a;

  // field positions, buck limit register
  localparam int RAX_ILIM_LSB   = 0;
  localparam int RAX_ILIM_MSB   = 1;
  localparam int RAX_SCHEME_BIT = 4;

  // field positions, backup supply register
  localparam int RAX_VOLT_LSB  = 0;
  localparam int RAX_VOLT_MSB  = 2;
  localparam int RAX_EVAL_BIT  = 3;
  localparam int RAX_FORCE_BIT = 4;
  localparam int RAX_BGOFF_BIT = 5;

  // field positions, memory reference register
  localparam int RAX_MR_EN_BIT    = 0;
  localparam int RAX_MR_STBY_BIT  = 1;
  localparam int RAX_MR_SLEEP_BIT = 2;
  localparam int RAX_MR_LP_BIT    = 3;

  // reset values
  localparam logic [1:0] RAX_ILIM_RST = 2'h0;
  localparam logic [2:0] RAX_VOLT_RST = 3'h0;
  localparam logic       RAX_BIT_RST  = 1'b0;
  localparam logic [7:0] RAX_BYTE_RST = 8'h00;

  // serial link: 7-bit device address (value arbitrary)
  localparam logic [6:0] RAX_DEV_ADDR = 7'h08;
  localparam logic [3:0] RAX_BYTE_BITS = 4'h8;
  localparam logic [3:0] RAX_CNT_RST   = 4'h0;
  localparam logic [7:0] RAX_PTR_STEP  = 8'h01;
  localparam logic       RAX_SDA_LOW   = 1'b0;

  // synchroniser lanes: clock line, data line, undervoltage comparator
  localparam int         RAX_SYNC_WIDTH = 3;
  localparam int         RAX_SYNC_SCL   = 0;
  localparam int         RAX_SYNC_SDA   = 1;
  localparam int         RAX_SYNC_UV    = 2;
  localparam logic [2:0] RAX_SYNC_IDLE  = 3'h3;

  // selection index inside the decode vector
  localparam int RAX_SEL_BUCK3  = 0;
  localparam int RAX_SEL_BACKUP = 1;
  localparam int RAX_SEL_MEMREF = 2;

  typedef enum logic [1:0]
  {
    RAX_PM_RUN,
    RAX_PM_STANDBY,
    RAX_PM_SLEEP,
    RAX_PM_OFF
  } rax_pwr_mode_type;

  // all stored control fields
  typedef struct packed
  {
    logic [1:0] buck3_current_limit_sel;
    logic       buck3_control_scheme_sel;
    logic [2:0] backup_supply_voltage_field;
    logic       eval_pulse_bit;
    logic       force_best_supply_bit;
    logic       coin_cell_bandgap_off;
    logic       memref_enable;
    logic       memref_standby_enable;
    logic       memref_sleep_enable;
    logic       memref_low_power;
  } rax_ctrl_type;

  // one register write strobe with its target and byte
  typedef struct packed
  {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } rax_wr_type;

  // one-hot register select, shared by write and read paths
  function automatic logic [2:0] rax_decode(input logic [7:0] addr);
    return {addr == RAX_ADDR_MEMREF, addr == RAX_ADDR_BACKUP,
            addr == RAX_ADDR_BUCK3};
  endfunction

endpackage

/* rax_pin_sync.sv */
`timescale 1ns/1ns
module rax_pin_sync
  import rax_pkg::*;
(
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [RAX_SYNC_WIDTH-1:0] async_i,
  output logic      [RAX_SYNC_WIDTH-1:0] sync_o
);

  logic [RAX_SYNC_WIDTH-1:0] ff1_r;
  logic [RAX_SYNC_WIDTH-1:0] ff2_r;
  logic [RAX_SYNC_WIDTH-1:0] ff3_r;
  logic [RAX_SYNC_WIDTH-1:0] out_r;

  // three stages; a change counts once stages two and three agree,
  // so a single-sample glitch on a slow line never reaches the fsm
  genvar g;
  generate
    for (g = 0; g < RAX_SYNC_WIDTH; g++)
    begin : g_lane
      always_ff @(posedge ref_clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          ff1_r[g] <= RAX_SYNC_IDLE[g];
          ff2_r[g] <= RAX_SYNC_IDLE[g];
          ff3_r[g] <= RAX_SYNC_IDLE[g];
          out_r[g] <= RAX_SYNC_IDLE[g];
        end
        else
        begin
          ff1_r[g] <= async_i[g];
          ff2_r[g] <= ff1_r[g];
          ff3_r[g] <= ff2_r[g];
          if (ff2_r[g] == ff3_r[g])
            out_r[g] <= ff3_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = out_r;

endmodule

/* rax_ctrl_regs.sv */
`timescale 1ns/1ns
module rax_ctrl_regs
  import rax_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire rax_pkg::rax_wr_type   wr_i,
  input  wire logic [7:0]            rd_addr_i,
  input  wire logic                  otp_load_i,
  input  wire logic                  otp_memref_en_i,
  input  wire logic                  otp_memref_stby_i,
  output rax_pkg::rax_ctrl_type      ctrl_o,
  output logic [7:0]                 rd_data_o
);

  rax_ctrl_type ctrl_r;
  logic [2:0]   wsel;
  logic [2:0]   rsel;

  assign wsel = wr_i.wr ? rax_decode(wr_i.addr) : 3'h0;
  assign rsel = rax_decode(rd_addr_i);

  // buck limit register: only the defined fields are stored
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r.buck3_current_limit_sel  <= RAX_ILIM_RST;
      ctrl_r.buck3_control_scheme_sel <= RAX_BIT_RST;
    end
    else if (wsel[RAX_SEL_BUCK3])
    begin
      ctrl_r.buck3_current_limit_sel  <=
        wr_i.data[RAX_ILIM_MSB:RAX_ILIM_LSB];
      ctrl_r.buck3_control_scheme_sel <=
        wr_i.data[RAX_SCHEME_BIT];
    end
  end

  // backup supply register; the voltage field is stored only
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r.backup_supply_voltage_field <= RAX_VOLT_RST;
      ctrl_r.eval_pulse_bit              <= RAX_BIT_RST;
      ctrl_r.force_best_supply_bit       <= RAX_BIT_RST;
      ctrl_r.coin_cell_bandgap_off       <= RAX_BIT_RST;
    end
    else if (wsel[RAX_SEL_BACKUP])
    begin
      ctrl_r.backup_supply_voltage_field <=
        wr_i.data[RAX_VOLT_MSB:RAX_VOLT_LSB];
      ctrl_r.eval_pulse_bit        <= wr_i.data[RAX_EVAL_BIT];
      ctrl_r.force_best_supply_bit <= wr_i.data[RAX_FORCE_BIT];
      ctrl_r.coin_cell_bandgap_off <= wr_i.data[RAX_BGOFF_BIT];
    end
  end

  // memory reference register; the power-up load wins over a write
  // in the same cycle since it models the sequencer taking control
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r.memref_enable         <= RAX_BIT_RST;
      ctrl_r.memref_standby_enable <= RAX_BIT_RST;
      ctrl_r.memref_sleep_enable   <= RAX_BIT_RST;
      ctrl_r.memref_low_power      <= RAX_BIT_RST;
    end
    else if (otp_load_i)
    begin
      ctrl_r.memref_enable         <= otp_memref_en_i;
      ctrl_r.memref_standby_enable <= otp_memref_stby_i;
    end
    else if (wsel[RAX_SEL_MEMREF])
    begin
      ctrl_r.memref_enable         <= wr_i.data[RAX_MR_EN_BIT];
      ctrl_r.memref_standby_enable <= wr_i.data[RAX_MR_STBY_BIT];
      ctrl_r.memref_sleep_enable   <= wr_i.data[RAX_MR_SLEEP_BIT];
      ctrl_r.memref_low_power      <= wr_i.data[RAX_MR_LP_BIT];
    end
  end

  // readback: unused and unmapped bits read as zero
  always_comb
  begin
    rd_data_o = RAX_BYTE_RST;
    if (rsel[RAX_SEL_BUCK3])
    begin
      rd_data_o[RAX_ILIM_MSB:RAX_ILIM_LSB] =
        ctrl_r.buck3_current_limit_sel;
      rd_data_o[RAX_SCHEME_BIT] = ctrl_r.buck3_control_scheme_sel;
    end
    else if (rsel[RAX_SEL_BACKUP])
    begin
      rd_data_o[RAX_VOLT_MSB:RAX_VOLT_LSB] =
        ctrl_r.backup_supply_voltage_field;
      rd_data_o[RAX_EVAL_BIT]  = ctrl_r.eval_pulse_bit;
      rd_data_o[RAX_FORCE_BIT] = ctrl_r.force_best_supply_bit;
      rd_data_o[RAX_BGOFF_BIT] = ctrl_r.coin_cell_bandgap_off;
    end
    else if (rsel[RAX_SEL_MEMREF])
    begin
      rd_data_o[RAX_MR_EN_BIT]    = ctrl_r.memref_enable;
      rd_data_o[RAX_MR_STBY_BIT]  = ctrl_r.memref_standby_enable;
      rd_data_o[RAX_MR_SLEEP_BIT] = ctrl_r.memref_sleep_enable;
      rd_data_o[RAX_MR_LP_BIT]    = ctrl_r.memref_low_power;
    end
  end

  assign ctrl_o = ctrl_r;

endmodule

/* rax_regulator_aux_ctrl.sv */
// Overview of operation
// - two-bit third buck current limit at bits 1:0, reset 00, four limits
// - bit 4 picks on-time control when 0, off-time control when 1
// - backup supply voltage field bits 2:0, reset 000, drives nothing
// - bit 3 of backup register is a read/write evaluation bit, reset 0
// - best-of-supply active on undervoltage only, or always when forced
// - bit 5 set turns off backup bandgap in coin-cell mode
// - memory reference main enable at bit 0, reset 0, set by power-up load
// - standby enable keeps reference on in standby only with main enable
// - sleep enable keeps reference on in sleep only with main enable
// - bit 3 selects the reference low-power operating mode, reset 0
`timescale 1ns/1ns
module rax_regulator_aux_ctrl
  import rax_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  input  wire logic                    supply_below_uv_i,
  input  wire rax_pkg::rax_pwr_mode_type pwr_mode_i,
  input  wire logic                    otp_load_i,
  input  wire logic                    otp_memref_en_i,
  input  wire logic                    otp_memref_stby_i,
  output logic [1:0]                   buck3_current_limit_sel_o,
  output logic                         buck3_control_scheme_sel_o,
  output logic                         eval_pulse_bit_o,
  output logic                         best_of_supply_active_o,
  output logic                         coin_cell_bandgap_off_o,
  output logic                         memref_on_o,
  output logic                         memref_low_power_o
);

  typedef enum logic [2:0]
    {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD, ST_WAIT} rax_link_state_type;

  rax_link_state_type state_r;
  logic [RAX_SYNC_WIDTH-1:0] sync_s;
  logic [3:0]   bit_cnt_r;
  logic         ack_phase_r;
  logic [7:0]   shift_r;
  logic [7:0]   tx_r;
  logic [7:0]   ptr_r;
  logic         scl_d_r;
  logic         sda_d_r;
  logic         sda_oe_r;
  logic         sda_out_r;
  rax_wr_type   wr_r;
  rax_ctrl_type ctrl_s;
  logic [7:0]   rd_data_s;
  logic         scl_s;
  logic         sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         byte_done;
  logic         ack_end;
  logic         addr_hit;

  // pins and the comparator come from outside the clock domain
  rax_pin_sync u_sync
  (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({supply_below_uv_i, sda_i, scl_i}),
    .sync_o    (sync_s)
  );

  rax_ctrl_regs u_regs
  (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .wr_i              (wr_r),
    .rd_addr_i         (ptr_r),
    .otp_load_i        (otp_load_i),
    .otp_memref_en_i   (otp_memref_en_i),
    .otp_memref_stby_i (otp_memref_stby_i),
    .ctrl_o            (ctrl_s),
    .rd_data_o         (rd_data_s)
  );

  // line edges and bus conditions, from the filtered samples
  assign scl_s     = sync_s[RAX_SYNC_SCL];
  assign sda_s     = sync_s[RAX_SYNC_SDA];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_done = scl_fall & ~ack_phase_r & (bit_cnt_r == RAX_BYTE_BITS);
  assign ack_end   = scl_fall & ack_phase_r;
  assign addr_hit  = shift_r[7:1] == RAX_DEV_ADDR;

  // previous line levels for edge detection
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_d_r <= RAX_SYNC_IDLE[RAX_SYNC_SCL];
      sda_d_r <= RAX_SYNC_IDLE[RAX_SYNC_SDA];
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // byte framing: start and stop override everything in flight
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= RAX_CNT_RST;
      ack_phase_r <= 1'b0;
      shift_r     <= RAX_BYTE_RST;
    end
    else if (start_det)
    begin
      state_r     <= ST_DEV;
      bit_cnt_r   <= RAX_CNT_RST;
      ack_phase_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r     <= ST_IDLE;
      ack_phase_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_phase_r)
      begin
        // a master nack ends a read burst
        if (state_r == ST_RD && sda_s)
          state_r <= ST_WAIT;
      end
      else if (bit_cnt_r != RAX_BYTE_BITS)
      begin
        shift_r   <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
    else if (ack_end)
      ack_phase_r <= 1'b0;
    else if (byte_done)
    begin
      bit_cnt_r   <= RAX_CNT_RST;
      ack_phase_r <= 1'b1;
      unique case (state_r)
        ST_DEV  : state_r <= !addr_hit ? ST_WAIT : shift_r[0] ? ST_RD : ST_REG;
        ST_REG  : state_r <= ST_WR;
        default : state_r <= state_r;
      endcase
    end
  end

  // register pointer and write strobe; the pointer steps per written byte and per master-acked read byte
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ptr_r   <= RAX_BYTE_RST;
      wr_r.wr <= 1'b0;
      wr_r.addr <= RAX_BYTE_RST;
      wr_r.data <= RAX_BYTE_RST;
    end
    else
    begin
      wr_r.wr <= 1'b0;
      if (byte_done && state_r == ST_REG)
        ptr_r <= shift_r;
      else if (byte_done && state_r == ST_WR)
      begin
        // unmapped targets take the strobe but store nothing
        wr_r.wr   <= 1'b1;
        wr_r.addr <= ptr_r;
        wr_r.data <= shift_r;
        ptr_r     <= ptr_r + RAX_PTR_STEP;
      end
      else if (scl_rise && ack_phase_r && !sda_oe_r && !sda_s &&
               state_r == ST_RD)  // our own address ack is not a step
        ptr_r <= ptr_r + RAX_PTR_STEP;
    end
  end

  // data line drive: open drain, so only the enable ever moves
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sda_oe_r  <= 1'b0;
      sda_out_r <= RAX_SDA_LOW;
      tx_r      <= RAX_BYTE_RST;
    end
    else if (start_det || stop_det)
      sda_oe_r <= 1'b0;
    else if (ack_end)
    begin
      sda_oe_r <= 1'b0;
      if (state_r == ST_RD)
      begin
        // load the byte at the fall so the line settles before scl rises
        sda_oe_r <= ~rd_data_s[7];
        tx_r     <= {rd_data_s[6:0], 1'b0};
      end
    end
    else if (byte_done)
      sda_oe_r <= (state_r == ST_DEV && addr_hit) ||
                  state_r == ST_REG || state_r == ST_WR;
    else if (scl_fall && state_r == ST_RD && !ack_phase_r &&
             bit_cnt_r != RAX_CNT_RST)
    begin
      sda_oe_r <= ~tx_r[7];
      tx_r     <= {tx_r[6:0], 1'b0};
    end
  end

  // regulator controls; unused buck bits are never stored or read
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      buck3_current_limit_sel_o  <= RAX_ILIM_RST;
      buck3_control_scheme_sel_o <= RAX_BIT_RST;
      eval_pulse_bit_o           <= RAX_BIT_RST;
      coin_cell_bandgap_off_o    <= RAX_BIT_RST;
      memref_low_power_o         <= RAX_BIT_RST;
    end
    else
    begin
      buck3_current_limit_sel_o  <= ctrl_s.buck3_current_limit_sel;
      buck3_control_scheme_sel_o <= ctrl_s.buck3_control_scheme_sel;
      eval_pulse_bit_o           <= ctrl_s.eval_pulse_bit;
      coin_cell_bandgap_off_o    <= ctrl_s.coin_cell_bandgap_off;
      memref_low_power_o         <= ctrl_s.memref_low_power;
    end
  end

  // supply selection and memory reference on state per power mode
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      best_of_supply_active_o <= 1'b0;
      memref_on_o             <= 1'b0;
    end
    else
    begin
      best_of_supply_active_o <= ctrl_s.force_best_supply_bit |
                                 sync_s[RAX_SYNC_UV];
      unique case (pwr_mode_i)
        RAX_PM_RUN     : memref_on_o <= ctrl_s.memref_enable;
        RAX_PM_STANDBY : memref_on_o <= ctrl_s.memref_enable &
                                        ctrl_s.memref_standby_enable;
        RAX_PM_SLEEP   : memref_on_o <= ctrl_s.memref_enable &
                                        ctrl_s.memref_sleep_enable;
        RAX_PM_OFF     : memref_on_o <= 1'b0;
      endcase
    end
  end

  assign sda_o    = sda_out_r;
  assign sda_oe_o = sda_oe_r;

  // checks on the control path
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [2:0] wsel_s;
  assign wsel_s = wr_r.wr ? rax_decode(wr_r.addr) : 3'h0;
  property p_ilim;
    wsel_s[RAX_SEL_BUCK3] && wr_r.data[1:0] == 2'h3
      |-> ##2 buck3_current_limit_sel_o == 2'h3;
  endproperty
  a_ilim : assert property (p_ilim)
    else $error("current limit not taken from write");
  property p_scheme;
    wsel_s[RAX_SEL_BUCK3] |-> ##2
      buck3_control_scheme_sel_o == $past(wr_r.data[RAX_SCHEME_BIT], 2);
  endproperty
  a_scheme : assert property (p_scheme)
    else $error("control scheme not taken from write");
  property p_eval;
    wsel_s[RAX_SEL_BACKUP] && wr_r.data[RAX_EVAL_BIT] |-> ##2 eval_pulse_bit_o;
  endproperty
  a_eval : assert property (p_eval)
    else $error("evaluation bit not taken from write");
  property p_force;
    ctrl_s.force_best_supply_bit[*2] |-> best_of_supply_active_o;
  endproperty
  a_force : assert property (p_force)
    else $error("best supply not forced");
  property p_bgoff;
    wsel_s[RAX_SEL_BACKUP] && !wr_r.data[RAX_BGOFF_BIT]
      |-> ##2 !coin_cell_bandgap_off_o;
  endproperty
  a_bgoff : assert property (p_bgoff)
    else $error("bandgap off bit not cleared by write");
  property p_otp_en;
    otp_load_i && otp_memref_en_i && pwr_mode_i == RAX_PM_RUN
      ##1 pwr_mode_i == RAX_PM_RUN |=> memref_on_o;
  endproperty
  a_otp_en : assert property (p_otp_en)
    else $error("power-up load did not enable reference");
  property p_stby;
    pwr_mode_i == RAX_PM_STANDBY && !ctrl_s.memref_enable |=> !memref_on_o;
  endproperty
  a_stby : assert property (p_stby)
    else $error("reference on in standby without main enable");
  property p_sleep;
    pwr_mode_i == RAX_PM_SLEEP && ctrl_s.memref_enable &&
      ctrl_s.memref_sleep_enable |=> memref_on_o;
  endproperty
  a_sleep : assert property (p_sleep)
    else $error("reference off in sleep despite enables");
  property p_lp;
    wsel_s[RAX_SEL_MEMREF] && !otp_load_i && wr_r.data[RAX_MR_LP_BIT]
      |-> ##2 memref_low_power_o;
  endproperty
  a_lp : assert property (p_lp)
    else $error("low-power bit not taken from write");
  property p_unused;
    ptr_r == RAX_ADDR_BUCK3 |-> rd_data_s[7:5] == 3'h0 &&
      rd_data_s[3:2] == 2'h0;
  endproperty
  a_unused : assert property (p_unused)
    else $error("unused buck bits read nonzero");

  c_write : cover property (wsel_s[RAX_SEL_MEMREF]);
  c_read  : cover property (ack_end && state_r == ST_RD);
  c_sleep : cover property (pwr_mode_i == RAX_PM_SLEEP && memref_on_o);
  c_force : cover property (best_of_supply_active_o && !sync_s[RAX_SYNC_UV]);

endmodule

/* rax_host_model.sv */
`timescale 1ns/1ns
module rax_host_model
  import rax_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // clock stands high between frames, data released to the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ten cycles per phase, clear of the device input filter
  task automatic hp();
    repeat (10) @(posedge ref_clk_i);
  endtask
  // also serves as repeated start, entered with the clock low
  task automatic start();
    sda_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b1;
    hp();
  endtask
  // data set while clock low, line sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    hp();
    scl_o <= 1'b1;
    hp();
    r = sda_i;
    scl_o <= 1'b0;
    hp();
  endtask
  // msb first, counts an acknowledge
  task automatic tx(input logic [7:0] d, inout int na);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    if (r === 1'b0)
      na++;
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, d,
                    output int na);
    na = 0;
    start();
    tx({dv, 1'b0}, na);
    tx(a, na);
    tx(d, na);
    stop();
  endtask
  // single byte read, closed with a not-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output int na);
    logic r;
    na = 0;
    start();
    tx({RAX_DEV_ADDR, 1'b0}, na);
    tx(a, na);
    start();
    tx({RAX_DEV_ADDR, 1'b1}, na);
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(1'b1, r);
    stop();
  endtask
endmodule

/* rax_regulator_aux_ctrl_test.sv */
`timescale 1ns/1ns
module rax_regulator_aux_ctrl_test;
  import rax_pkg::*;
  logic             ref_clk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             uv        = 1'b0;
  rax_pwr_mode_type mode      = RAX_PM_RUN;
  logic             ld        = 1'b0;
  logic             ld_en     = 1'b0;
  logic             ld_stby   = 1'b0;
  logic             scl, hsda, dsda, doe, sda;
  logic [1:0]       lim;
  logic             sch, ev, best_of_supply, bg, mr_on, lp;
  logic [7:0]       outs, q;
  logic [7:0]       r42       = 8'h00;
  logic [7:0]       r48       = 8'h00;
  logic [7:0]       r4a       = 8'h00;
  logic [31:0]      seed      = 32'h36a9fcb2;
  logic [7:0]       adr [4]   = '{8'h42, 8'h48, 8'h4a, 8'h4b};
  int               n_errors  = 0;
  int               compares  = 0;
  int               cyc       = 0;
  int               na;
  always #5 ref_clk_i = ~ref_clk_i;
  // open drain data wire with pull-up
  assign sda = hsda & (doe ? dsda : 1'b1);
  assign outs = {lim, sch, ev, best_of_supply, bg, mr_on, lp};
  rax_host_model u_host (.ref_clk_i(ref_clk_i), .sda_i(sda),
                         .scl_o(scl), .sda_o(hsda));
  rax_regulator_aux_ctrl u_dut (
    .ref_clk_i                 (ref_clk_i),
    .reset_n_i                 (reset_n_i),
    .scl_i                     (scl),
    .sda_i                     (sda),
    .sda_o                     (dsda),
    .sda_oe_o                  (doe),
    .supply_below_uv_i         (uv),
    .pwr_mode_i                (mode),
    .otp_load_i                (ld),
    .otp_memref_en_i           (ld_en),
    .otp_memref_stby_i         (ld_stby),
    .buck3_current_limit_sel_o (lim),
    .buck3_control_scheme_sel_o(sch),
    .eval_pulse_bit_o          (ev),
    .best_of_supply_active_o   (best_of_supply),
    .coin_cell_bandgap_off_o   (bg),
    .memref_on_o               (mr_on),
    .memref_low_power_o        (lp)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // readable bits only, unmapped places read zero
  function automatic logic [7:0] msk(input logic [7:0] a, d);
    case (a)
      RAX_ADDR_BUCK3:  return d & 8'h13;
      RAX_ADDR_BACKUP: return d & 8'h3f;
      RAX_ADDR_MEMREF: return d & 8'h0f;
      default:         return 8'h00;
    endcase
  endfunction
  // voltage field bits 2:0 deliberately feed nothing
  function automatic logic [7:0] exp_out();
    logic o;
    case (mode)
      RAX_PM_RUN:     o = r4a[0];
      RAX_PM_STANDBY: o = r4a[0] & r4a[1];
      RAX_PM_SLEEP:   o = r4a[0] & r4a[2];
      default:        o = 1'b0;
    endcase
    return {r42[1:0], r42[4], r48[3], r48[4] | uv, r48[5], o, r4a[3]};
  endfunction
  task automatic chk(input logic [7:0] g, e, input string m);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  // long enough for the pin synchroniser and output flop
  task automatic st();
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic wr_chk(input logic [7:0] a, d);
    u_host.wr(RAX_DEV_ADDR, a, d, na);
    chk(8'(na), 8'h03, "wr ack");
    case (a)
      RAX_ADDR_BUCK3:  r42 = msk(a, d);
      RAX_ADDR_BACKUP: r48 = msk(a, d);
      RAX_ADDR_MEMREF: r4a = msk(a, d);
      default: ;
    endcase
    u_host.rd(a, q, na);
    chk(q, msk(a, d), "readback");
    st();
    chk(outs, exp_out(), "outs");
  endtask
  task automatic sweep();
    for (int m = 3; m >= 0; m--)
      for (int u = 0; u < 2; u++)
      begin
        @(posedge ref_clk_i);
        mode <= rax_pwr_mode_type'(m);
        uv <= u[0];
        st();
        chk(outs, exp_out(), "mode");
      end
    $display("test sweep done");
  endtask
  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    st();
    chk(outs, exp_out(), "rst outs");
    for (int i = 0; i < 3; i++)
    begin
      u_host.rd(adr[i], q, na);
      chk(q, 8'h00, "rst value");
    end
    $display("test reset done");
    // loader sets main and standby enables from their own load inputs
    @(posedge ref_clk_i);
    ld <= 1'b1;
    ld_en <= 1'b1;
    ld_stby <= 1'b1;
    @(posedge ref_clk_i);
    ld <= 1'b0;
    r4a = 8'h03;
    u_host.rd(RAX_ADDR_MEMREF, q, na);
    chk(q, 8'h03, "otp load");
    sweep();
    // every limit code, junk in unused bits
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      wr_chk(RAX_ADDR_BUCK3, {seed[5:0], i[1:0]});
    end
    for (int i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      wr_chk(adr[seed[9:8]], seed[7:0]);
    end
    $display("test random done");
    sweep();
    u_host.wr(RAX_DEV_ADDR ^ 7'h01, RAX_ADDR_BUCK3, 8'hff, na);
    chk(8'(na), 8'h00, "foreign addr");
    st();
    chk(outs, exp_out(), "foreign outs");
    $display("test addr done");
    complete_run();
  end
endmodule
